// ==== verilog/odbt_pkg.sv ====
`default_nettype none
package odbt_pkg;
  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0] ADR_BGSC  = 8'h00;
  localparam logic [7:0] ADR_BGBK  = 8'h04;
  localparam logic [7:0] ADR_CMPA  = 8'h08;
  localparam logic [7:0] ADR_CMPB  = 8'h0c;
  localparam logic [7:0] ADR_FIFOH = 8'h10;
  localparam logic [7:0] ADR_FIFOL = 8'h14;
  localparam logic [7:0] ADR_DEBUG_CONTROL_REG  = 8'h18;
  localparam logic [7:0] ADR_TRGC  = 8'h1c;
  localparam logic [7:0] ADR_DEBUG_STATUS_REG  = 8'h20;

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int BGSC_EN    = 0;
  localparam int BGSC_FTS   = 1;
  localparam int DEBUG_CONTROL_REG_ARM   = 0;
  localparam int DEBUG_CONTROL_REG_BRK   = 1;
  localparam int DEBUG_CONTROL_REG_TAG   = 2;
  localparam int DEBUG_CONTROL_REG_COMP_A_RW_QUALIFY_ENABLE = 3;
  localparam int DEBUG_CONTROL_REG_RWA   = 4;
  localparam int DEBUG_CONTROL_REG_RWBEN = 5;
  localparam int DEBUG_CONTROL_REG_RWB   = 6;
  localparam int TRGC_TSEL  = 4;
  localparam int TRGC_BEGIN = 5;
  localparam logic [1:0]  RST_BGSC  = 2'h0;
  localparam logic [15:0] RST_ADR16 = 16'h0000;
  localparam logic [6:0]  RST_DEBUG_CONTROL_REG  = 7'h00;
  localparam logic [5:0]  RST_TRGC  = 6'h00;
  localparam logic [3:0]  FIFO_FULL = 4'h8;
  localparam logic [1:0]  COF_SKIP  = 2'h2;

  typedef enum logic [3:0] {
    TM_A    = 4'h0, TM_AORB = 4'h1, TM_ATHB = 4'h2, TM_EVB = 4'h3, TM_AEVB = 4'h4,
    TM_FULL = 4'h5, TM_FNOT = 4'h6, TM_IN   = 4'h7, TM_OUT = 4'h8
  } odbt_mode_t;

  typedef enum logic [1:0] {
    CK_COND = 2'h0, CK_UNCOND = 2'h1, CK_INDIR = 2'h2, CK_RET = 2'h3
  } odbt_cof_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001, RS_WAIT = 3'b010, RS_STORE = 3'b100
  } odbt_run_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] adr;
    logic [7:0]  rdat;
    logic [7:0]  wdat;
    logic        rw;
    logic        opfetch;
    logic        bdc;
    logic        exec;
    logic [1:0]  exec_trk;
  } odbt_bus_t;

  typedef struct packed {
    logic        valid;
    odbt_cof_t   kind;
    logic [15:0] src;
    logic [15:0] dst;
  } odbt_cofi_t;
endpackage : odbt_pkg
`default_nettype wire

// ==== verilog/odbt_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Background breakpoint compares every bus address with a 16-bit match value.
// - Forced type breaks at next instruction boundary after any access to it.
// - Tagged type marks the fetched opcode; break only if it reaches queue end.
// - Breakpoint enable resets to zero; while zero no background breakpoint.
// - Force/tag select 1 chooses forced, 0 chooses tagged.
// - Eight-entry capture FIFO holds address or data words.
// - Comparators A and B, own read/write qualify, range compare support.
// - Tag triggering passes each comparator through its own opcode tracker.
// - Comparators disabled during background controller accesses.
// - A compares address; B compares address or data by mode.
// - B uses write data when A qualify enabled and set to write.
// - Match gives breakpoint, data store, trace start or trace end.
// - Count shows valid words; host skips dummy reads after manual halt.
// - Host reads high then low byte; low byte read shifts FIFO.
// - Event-only modes store 8-bit data; low byte read shifts.
// - Change-of-flow at trigger or two cycles after begin is not stored.
// - End trace stores change-of-flow trigger event as last entry.
// - While not armed, low byte read pushes last fetched opcode address.
// - Taken conditional branch stores source; unconditional branches store nothing.
// - Indirect jump/call, interrupt and returns store destination address.
// - Tag break travels with opcode; force waits for instruction end.
// - Arm write 1 sets armed and clears match flags and count.
module odbt_top (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire odbt_pkg::odbt_bus_t  cpu_i,
  input  wire odbt_pkg::odbt_cofi_t cof_i,
  output logic                    cpu_force_bkpt_o,
  output logic                    cpu_tag_bkpt_o,
  output logic      [1:0]         cpu_trk_tag_o
);
  // ********************************
  // Register bus
  // ********************************
  logic [1:0]  bgsc_r;
  logic [15:0] bkpt_adr_r;
  logic [15:0] cmpa_r;
  logic [15:0] cmpb_r;
  logic [6:0]  debug_control_reg_r;
  logic [5:0]  trgc_r;
  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        arm_start;
  logic        arm_stop;
  logic        pop;
  odbt_pkg::odbt_run_t run_r;
  odbt_pkg::odbt_run_t run_nxt;
  logic [15:0] fifo_r [0:7];
  logic [15:0] fifo_nxt [0:7];
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        af_r;
  logic        bf_r;
  logic        armed;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [3:0] sel,
                                       input logic [31:0] d);
    wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : wr16

  assign req       = wb_cyc_i & wb_stb_i;
  // Writes and pops happen at the edge where the master sees ack
  assign wr_acc    = req & wb_ack_o & wb_we_i;
  assign rd_acc    = req & wb_ack_o & ~wb_we_i;
  assign arm_start = wr_acc & hit(wb_adr_i, odbt_pkg::ADR_DEBUG_CONTROL_REG) & wb_sel_i[0] & wb_dat_i[odbt_pkg::DEBUG_CONTROL_REG_ARM];
  assign arm_stop  = wr_acc & hit(wb_adr_i, odbt_pkg::ADR_DEBUG_CONTROL_REG) & wb_sel_i[0] & ~wb_dat_i[odbt_pkg::DEBUG_CONTROL_REG_ARM];
  assign pop       = rd_acc & hit(wb_adr_i, odbt_pkg::ADR_FIFOL);
  assign armed     = (run_r != odbt_pkg::RS_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o) begin
      unique case (wb_adr_i)
        odbt_pkg::ADR_BGSC:  wb_dat_o <= {30'h0, bgsc_r};
        odbt_pkg::ADR_BGBK:  wb_dat_o <= {16'h0, bkpt_adr_r};
        odbt_pkg::ADR_CMPA:  wb_dat_o <= {16'h0, cmpa_r};
        odbt_pkg::ADR_CMPB:  wb_dat_o <= {16'h0, cmpb_r};
        odbt_pkg::ADR_FIFOH: wb_dat_o <= {24'h0, fifo_r[0][15:8]};
        odbt_pkg::ADR_FIFOL: wb_dat_o <= {24'h0, fifo_r[0][7:0]};
        odbt_pkg::ADR_DEBUG_CONTROL_REG:  wb_dat_o <= {25'h0, debug_control_reg_r[6:1], armed};
        odbt_pkg::ADR_TRGC:  wb_dat_o <= {26'h0, trgc_r};
        odbt_pkg::ADR_DEBUG_STATUS_REG:  wb_dat_o <= {25'h0, armed, bf_r, af_r, cnt_r};
        default:             wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bgsc_r     <= odbt_pkg::RST_BGSC;
      bkpt_adr_r <= odbt_pkg::RST_ADR16;
      cmpa_r     <= odbt_pkg::RST_ADR16;
      cmpb_r     <= odbt_pkg::RST_ADR16;
      debug_control_reg_r     <= odbt_pkg::RST_DEBUG_CONTROL_REG;
      trgc_r     <= odbt_pkg::RST_TRGC;
    end else if (wr_acc) begin
      if (hit(wb_adr_i, odbt_pkg::ADR_BGSC) && wb_sel_i[0]) begin
        bgsc_r <= wb_dat_i[1:0];
      end
      if (hit(wb_adr_i, odbt_pkg::ADR_BGBK)) begin
        bkpt_adr_r <= wr16(bkpt_adr_r, wb_sel_i, wb_dat_i);
      end
      if (hit(wb_adr_i, odbt_pkg::ADR_CMPA)) begin
        cmpa_r <= wr16(cmpa_r, wb_sel_i, wb_dat_i);
      end
      if (hit(wb_adr_i, odbt_pkg::ADR_CMPB)) begin
        cmpb_r <= wr16(cmpb_r, wb_sel_i, wb_dat_i);
      end
      if (hit(wb_adr_i, odbt_pkg::ADR_DEBUG_CONTROL_REG) && wb_sel_i[0]) begin
        debug_control_reg_r <= wb_dat_i[6:0];
      end
      if (hit(wb_adr_i, odbt_pkg::ADR_TRGC) && wb_sel_i[0]) begin
        trgc_r <= wb_dat_i[5:0];
      end
    end
  end

  // ********************************
  // Comparators and trigger
  // ********************************
  logic       bus_ok;
  logic       rwq_a;
  logic       rwq_b;
  logic [7:0] dsel;
  logic       raw_a;
  logic       raw_b;
  logic       qa;
  logic       qb;
  logic       deq;
  logic       trig;
  logic       tsel;
  logic       evonly;
  logic       begin_t;
  logic       a_seen_r;
  odbt_pkg::odbt_mode_t mode;

  assign mode    = odbt_pkg::odbt_mode_t'(trgc_r[3:0]);
  assign tsel    = trgc_r[odbt_pkg::TRGC_TSEL];
  assign evonly  = (mode == odbt_pkg::TM_EVB) | (mode == odbt_pkg::TM_AEVB);
  assign begin_t = trgc_r[odbt_pkg::TRGC_BEGIN] | evonly;
  assign bus_ok  = cpu_i.valid & ~cpu_i.bdc;
  assign rwq_a   = ~debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_COMP_A_RW_QUALIFY_ENABLE] | (cpu_i.rw == debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_RWA]);
  assign rwq_b   = ~debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_RWBEN] | (cpu_i.rw == debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_RWB]);
  // Write bus only for enabled write qualification
  assign dsel    = (debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_COMP_A_RW_QUALIFY_ENABLE] & ~debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_RWA]) ? cpu_i.wdat : cpu_i.rdat;
  assign raw_a   = bus_ok & rwq_a & (cpu_i.adr == cmpa_r);
  assign raw_b   = bus_ok & rwq_b & (cpu_i.adr == cmpb_r);
  assign deq     = (dsel == cmpb_r[7:0]);
  // Tracker tags ride the queue with the opcode; only executed ones come back
  assign qa      = tsel ? (cpu_i.exec & cpu_i.exec_trk[0]) : raw_a;
  assign qb      = tsel ? (cpu_i.exec & cpu_i.exec_trk[1]) : raw_b;

  always_comb begin
    unique case (mode)
      odbt_pkg::TM_A:    trig = qa;
      odbt_pkg::TM_AORB: trig = qa | qb;
      odbt_pkg::TM_ATHB: trig = a_seen_r & qb;
      odbt_pkg::TM_EVB:  trig = qb;
      odbt_pkg::TM_AEVB: trig = a_seen_r & qb;
      odbt_pkg::TM_FULL: trig = qa & deq;
      odbt_pkg::TM_FNOT: trig = qa & ~deq;
      odbt_pkg::TM_IN:   trig = bus_ok & (cpu_i.adr >= cmpa_r) & (cpu_i.adr <= cmpb_r);
      odbt_pkg::TM_OUT:  trig = bus_ok & ((cpu_i.adr < cmpa_r) | (cpu_i.adr > cmpb_r));
      default:           trig = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_seen_r <= 1'b0;
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
    end else begin
      // A match in the arming cycle still counts: set wins over clear
      a_seen_r <= (arm_start ? 1'b0 : a_seen_r) | ((armed | arm_start) & qa);
      af_r     <= (arm_start ? 1'b0 : af_r) | ((armed | arm_start) & qa);
      bf_r     <= (arm_start ? 1'b0 : bf_r) | ((armed | arm_start) & qb);
    end
  end

  // ********************************
  // Run control and FIFO
  // ********************************
  logic [1:0]  skip_r;
  logic [15:0] last_op_r;
  logic        cof_ok;
  logic [15:0] cof_adr;
  logic        push;
  logic [15:0] push_val;
  logic        prof;

  assign cof_ok  = cof_i.valid & (cof_i.kind != odbt_pkg::CK_UNCOND);
  assign cof_adr = (cof_i.kind == odbt_pkg::CK_COND) ? cof_i.src : cof_i.dst;
  assign prof    = (run_r == odbt_pkg::RS_IDLE) & pop;

  always_comb begin
    push     = 1'b0;
    push_val = 16'h0000;
    if (prof) begin
      push     = 1'b1;
      push_val = last_op_r;
    end else if (run_r == odbt_pkg::RS_STORE && !(begin_t && cnt_r == odbt_pkg::FIFO_FULL)) begin
      if (evonly) begin
        push     = trig;
        push_val = {8'h00, dsel};
      end else begin
        // The end trace keeps the trigger's own change-of-flow as last entry
        push     = cof_ok & (skip_r == 2'h0);
        push_val = cof_adr;
      end
    end
  end

  always_comb begin
    logic [3:0] n;
    n = cnt_r;
    for (int i = 0; i < 8; i++) begin
      fifo_nxt[i] = fifo_r[i];
    end
    if (pop && (n != 4'h0)) begin
      for (int i = 0; i < 7; i++) begin
        fifo_nxt[i] = fifo_nxt[i+1];
      end
      n = n - 4'h1;
    end
    if (push) begin
      // A full FIFO drops its oldest word, giving circular end traces
      if (n == odbt_pkg::FIFO_FULL) begin
        for (int i = 0; i < 7; i++) begin
          fifo_nxt[i] = fifo_nxt[i+1];
        end
        fifo_nxt[7] = push_val;
      end else begin
        fifo_nxt[n[2:0]] = push_val;
        n = n + 4'h1;
      end
    end
    cnt_nxt = n;
  end

  generate
    for (genvar g = 0; g < 8; g++) begin : g_fifo
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fifo_r[g] <= 16'h0000;
        end else begin
          fifo_r[g] <= fifo_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else if (arm_start) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_op_r <= 16'h0000;
    end else if (cpu_i.valid && cpu_i.opfetch && !cpu_i.bdc) begin
      last_op_r <= cpu_i.adr;
    end
  end

  always_comb begin
    run_nxt = run_r;
    unique case (run_r)
      odbt_pkg::RS_IDLE: ;
      odbt_pkg::RS_WAIT: begin
        if (trig) begin
          run_nxt = odbt_pkg::RS_STORE;
        end
      end
      odbt_pkg::RS_STORE: begin
        if (begin_t && (cnt_r == odbt_pkg::FIFO_FULL)) begin
          run_nxt = odbt_pkg::RS_IDLE;
        end else if (!begin_t && trig) begin
          run_nxt = odbt_pkg::RS_IDLE;
        end
      end
    endcase
    if (arm_start) begin
      run_nxt = (begin_t && !evonly) ? odbt_pkg::RS_WAIT : odbt_pkg::RS_STORE;
    end else if (arm_stop) begin
      run_nxt = odbt_pkg::RS_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= odbt_pkg::RS_IDLE;
    end else begin
      run_r <= run_nxt;
    end
  end

  // Pipeline delay hides the begin trigger and the two bus cycles after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_r <= 2'h0;
    end else if (run_r == odbt_pkg::RS_WAIT && trig && !arm_stop) begin
      skip_r <= odbt_pkg::COF_SKIP;
    end else if (skip_r != 2'h0 && cpu_i.valid) begin
      skip_r <= skip_r - 2'h1;
    end
  end

  // ********************************
  // Breakpoint requests
  // ********************************
  logic bg_hit;
  logic dbg_brk;

  assign bg_hit  = bgsc_r[odbt_pkg::BGSC_EN] & cpu_i.valid & (cpu_i.adr == bkpt_adr_r);
  assign dbg_brk = debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_BRK] & armed & trig;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_force_bkpt_o <= 1'b0;
      cpu_tag_bkpt_o   <= 1'b0;
      cpu_trk_tag_o    <= 2'h0;
    end else begin
      // CPU finishes the current instruction before acting on a force
      cpu_force_bkpt_o <= (bg_hit & bgsc_r[odbt_pkg::BGSC_FTS])
                        | (dbg_brk & ~debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_TAG]);
      // Tag marks the opcode fetched one cycle earlier
      cpu_tag_bkpt_o   <= cpu_i.opfetch & ((bg_hit & ~bgsc_r[odbt_pkg::BGSC_FTS])
                        | (dbg_brk & debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_TAG]));
      cpu_trk_tag_o    <= {2{tsel & cpu_i.opfetch}} & {raw_b, raw_a};
    end
  end

  // ********************************
  // Checks
  // ********************************
  bkpt_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bgsc_r[odbt_pkg::BGSC_EN] && !debug_control_reg_r[odbt_pkg::DEBUG_CONTROL_REG_BRK] |=> !cpu_force_bkpt_o && !cpu_tag_bkpt_o)
    else $error("breakpoint while disabled");
  bg_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bg_hit && bgsc_r[odbt_pkg::BGSC_FTS] |=> cpu_force_bkpt_o)
    else $error("forced breakpoint missing");
  bg_tag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bg_hit && !bgsc_r[odbt_pkg::BGSC_FTS] && cpu_i.opfetch |=> cpu_tag_bkpt_o)
    else $error("tagged breakpoint missing");
  bdc_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_i.bdc && !tsel |-> !raw_a && !raw_b && !trig)
    else $error("comparator matched a debugger access");
  fifo_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_r <= odbt_pkg::FIFO_FULL)
    else $error("fifo count above eight");
  arm_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    arm_start |=> armed && cnt_r == 4'h0)
    else $error("arm did not start a clean run");
  pop_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pop && !push && !arm_start && cnt_r != 4'h0 |=> cnt_r == $past(cnt_r) - 4'h1)
    else $error("low byte read did not shift");
  prof_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prof && cnt_r == 4'h0 && !arm_start |=> cnt_r == 4'h1 && fifo_r[0] == $past(last_op_r))
    else $error("profiling read did not store opcode address");
  begin_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_r == odbt_pkg::RS_STORE && begin_t && cnt_r == odbt_pkg::FIFO_FULL && !arm_start
    |=> run_r == odbt_pkg::RS_IDLE)
    else $error("begin trace did not end when full");
  cof_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_r == odbt_pkg::RS_WAIT && trig && !arm_start && !arm_stop && !evonly
    |=> skip_r == odbt_pkg::COF_SKIP && !(push && !prof))
    else $error("change-of-flow stored too early");
  uncond_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !evonly && !prof && cof_i.valid && cof_i.kind == odbt_pkg::CK_UNCOND |-> !push)
    else $error("unconditional branch stored");
endmodule : odbt_top
`default_nettype wire

// ==== dv/odbt_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ********************************
// CPU bus and instruction queue
// ********************************
module odbt_cpu_model (
  input  wire logic                 clk_i,
  input  wire logic [1:0]           trk_i,
  output odbt_pkg::odbt_bus_t       cpu_o,
  output odbt_pkg::odbt_cofi_t      cof_o
);
  odbt_pkg::odbt_bus_t  bus_r;
  odbt_pkg::odbt_cofi_t cof_r;
  logic [1:0]           trk_r;
  logic                 flush;

  initial begin
    bus_r = '0;
    cof_r = '0;
    trk_r = 2'h0;
    flush = 1'b0;
  end

  // A tagged opcode executes the cycle after its tag returns, unless flushed
  always @(posedge clk_i) begin
    trk_r <= flush ? 2'h0 : trk_i;
  end

  always_comb begin
    cpu_o          = bus_r;
    cpu_o.exec     = |trk_r;
    cpu_o.exec_trk = trk_r;
  end

  assign cof_o = cof_r;

  // One bus cycle; k is {rw, opfetch, bdc}. The read bus carries the
  // complement of the write bus so a wrong bus pick cannot go unseen.
  task automatic step(input logic [15:0] a, input logic [2:0] k, input logic [7:0] d,
                      input odbt_pkg::odbt_cofi_t c);
    bus_r <= '{1'b1, a, ~d, d, k[2], k[1], k[0], 1'b0, 2'b00};
    cof_r <= c;
    @(posedge clk_i);
  endtask : step

  // Idle address and data lines show the inverse of their last value; the change-of-flow kind keeps its last value
  task automatic rel();
    bus_r <= '{1'b0, ~bus_r.adr, ~bus_r.rdat, ~bus_r.wdat, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00};
    cof_r <= '{1'b0, cof_r.kind, ~cof_r.src, ~cof_r.dst};
  endtask : rel

  // A flush throws queued opcodes away before they execute
  task automatic drop(input logic f);
    flush <= f;
  endtask : drop
endmodule : odbt_cpu_model
`default_nettype wire

// ==== dv/odbt_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module odbt_top_tb;
  // ********************************
  // Signals
  // ********************************
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc   = 1'b0;
  logic                 stb   = 1'b0;
  logic                 we    = 1'b0;
  logic [7:0]           adr   = 8'h00;
  logic [31:0]          wdat  = 32'h0;
  logic [31:0]          rdat;
  logic                 ack;
  odbt_pkg::odbt_bus_t  cpu;
  odbt_pkg::odbt_cofi_t cof;
  logic                 fbk;
  logic                 tbk;
  logic [1:0]           trk;
  int                   err_total = 0;
  int                   tests_run = 0;
  int                   nf = 0;
  int                   nt = 0;
  int                   bf = 0;
  int                   bt = 0;
  localparam odbt_pkg::odbt_cofi_t NC = '0;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [2:0] RD = 3'h4;
  localparam logic [2:0] OF = 3'h6;
  localparam logic [2:0] WR = 3'h0;
  localparam logic [2:0] BD = 3'h5;

  always #25 clk_i = ~clk_i;

  odbt_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_i(cpu), .cof_i(cof), .cpu_force_bkpt_o(fbk), .cpu_tag_bkpt_o(tbk), .cpu_trk_tag_o(trk));

  odbt_cpu_model mdl (.clk_i(clk_i), .trk_i(trk), .cpu_o(cpu), .cof_o(cof));

  always @(posedge clk_i) begin
    if (fbk === 1'b1) nf++;
    if (tbk === 1'b1) nt++;
  end

  // ********************************
  // Helpers
  // ********************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    if (n == 16) chk("wb_ack", 32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk($sformatf("reg %h", a), q & m, e);
  endtask : rc

  // Break pulses seen since the last call; the wait covers a tracked opcode's queue trip
  task automatic pc(input int ef, input int et);
    repeat (4) @(posedge clk_i);
    chk("force_pulses", nf - bf, ef);
    chk("tag_pulses", nt - bt, et);
    bf = nf;
    bt = nt;
  endtask : pc

  function automatic odbt_pkg::odbt_cofi_t cf(input odbt_pkg::odbt_cof_t k, input logic [15:0] s,
                                              input logic [15:0] t);
    cf = '{1'b1, k, s, t};
  endfunction : cf

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    rc(odbt_pkg::ADR_BGSC, ALL, 32'h0);
    rc(odbt_pkg::ADR_DEBUG_CONTROL_REG, ALL, 32'h0);
    rc(odbt_pkg::ADR_DEBUG_STATUS_REG, ALL, 32'h0);
    wr(8'h24, ALL);
    rc(8'h24, ALL, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bg;
    wr(odbt_pkg::ADR_BGBK, 32'h1234);
    wr(odbt_pkg::ADR_BGSC, 32'h2);
    mdl.step(16'h1234, RD, 8'h00, NC);
    mdl.rel();
    pc(0, 0);
    wr(odbt_pkg::ADR_BGSC, 32'h3);
    mdl.step(16'h1233, OF, 8'h00, NC);
    mdl.step(16'h1234, RD, 8'h00, NC);
    mdl.step(16'h1235, RD, 8'h00, NC);
    mdl.rel();
    pc(1, 0);
    wr(odbt_pkg::ADR_BGSC, 32'h1);
    mdl.step(16'h1234, OF, 8'h00, NC);
    mdl.rel();
    pc(0, 1);
    wr(odbt_pkg::ADR_BGSC, 32'h0);
    $display("test background breakpoint done");
  endtask : t_bg

  task automatic t_cmp;
    logic [3:0]  md [5] = '{4'h1, 4'h7, 4'h7, 4'h8, 4'h8};
    logic [15:0] ad [5] = '{16'h2010, 16'h2005, 16'h2011, 16'h2011, 16'h2005};
    int          ex [5] = '{1, 1, 0, 1, 0};
    wr(odbt_pkg::ADR_CMPA, 32'h2000);
    wr(odbt_pkg::ADR_CMPB, 32'h2010);
    wr(odbt_pkg::ADR_TRGC, 32'h0);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h3);
    mdl.step(16'h2000, BD, 8'h00, NC);
    mdl.rel();
    pc(0, 0);
    mdl.step(16'h2000, RD, 8'h00, NC);
    mdl.rel();
    pc(1, 0);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'hb);
    mdl.step(16'h2000, RD, 8'h00, NC);
    mdl.rel();
    pc(0, 0);
    mdl.step(16'h2000, WR, 8'h00, NC);
    mdl.rel();
    pc(1, 0);
    for (int i = 0; i < 5; i++) begin
      wr(odbt_pkg::ADR_TRGC, {28'h0, md[i]});
      wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h3);
      mdl.step(ad[i], RD, 8'h00, NC);
      mdl.rel();
      pc(ex[i], 0);
    end
    wr(odbt_pkg::ADR_CMPB, 32'h5a);
    wr(odbt_pkg::ADR_TRGC, 32'h5);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'hb);
    mdl.step(16'h2000, WR, 8'h5a, NC);
    mdl.rel();
    pc(1, 0);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'hb);
    mdl.step(16'h2000, WR, 8'ha5, NC);
    mdl.rel();
    pc(0, 0);
    wr(odbt_pkg::ADR_TRGC, 32'h0);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h7);
    mdl.step(16'h2000, OF, 8'h00, NC);
    mdl.rel();
    pc(0, 1);
    wr(odbt_pkg::ADR_TRGC, 32'h10);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h3);
    for (int f = 1; f >= 0; f--) begin
      mdl.drop(f[0]);
      mdl.step(16'h2000, OF, 8'h00, NC);
      mdl.rel();
      pc(1 - f, 0);
    end
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h0);
    $display("test comparators done");
  endtask : t_cmp

  task automatic t_evt;
    wr(odbt_pkg::ADR_CMPB, 32'h3000);
    wr(odbt_pkg::ADR_TRGC, 32'h3);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h1);
    mdl.step(16'h3000, RD, 8'h5e, NC);
    mdl.step(16'h3001, RD, 8'h00, NC);
    mdl.step(16'h3000, RD, 8'h5d, NC);
    mdl.step(16'h3000, RD, 8'h5c, NC);
    mdl.rel();
    repeat (3) @(posedge clk_i);
    rc(odbt_pkg::ADR_DEBUG_STATUS_REG, 32'hf, 32'h3);
    rc(odbt_pkg::ADR_FIFOL, ALL, 32'ha1);
    rc(odbt_pkg::ADR_FIFOL, ALL, 32'ha2);
    rc(odbt_pkg::ADR_FIFOL, ALL, 32'ha3);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h1);
    rc(odbt_pkg::ADR_DEBUG_STATUS_REG, 32'h7f, 32'h40);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h0);
    $display("test event store done");
  endtask : t_evt

  task automatic t_cof;
    logic [15:0] ex [3] = '{16'h4104, 16'h5000, 16'h6000};
    wr(odbt_pkg::ADR_CMPA, 32'h4000);
    wr(odbt_pkg::ADR_TRGC, 32'h20);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h1);
    mdl.step(16'h4000, OF, 8'h00, cf(odbt_pkg::CK_COND, 16'h4000, 16'h4010));
    mdl.step(16'h4001, RD, 8'h00, cf(odbt_pkg::CK_COND, 16'h4100, 16'h4110));
    mdl.step(16'h4002, RD, 8'h00, NC);
    mdl.step(16'h4003, OF, 8'h00, cf(odbt_pkg::CK_COND, 16'h4104, 16'h4200));
    mdl.step(16'h4004, OF, 8'h00, cf(odbt_pkg::CK_UNCOND, 16'h4204, 16'h4300));
    mdl.step(16'h4005, OF, 8'h00, cf(odbt_pkg::CK_INDIR, 16'h4208, 16'h5000));
    mdl.step(16'h4006, OF, 8'h00, cf(odbt_pkg::CK_RET, 16'h420c, 16'h6000));
    mdl.rel();
    repeat (3) @(posedge clk_i);
    rc(odbt_pkg::ADR_DEBUG_STATUS_REG, 32'hf, 32'h3);
    for (int i = 0; i < 3; i++) begin
      rc(odbt_pkg::ADR_FIFOH, ALL, {24'h0, ex[i][15:8]});
      rc(odbt_pkg::ADR_FIFOL, ALL, {24'h0, ex[i][7:0]});
    end
    wr(odbt_pkg::ADR_TRGC, 32'h0);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h1);
    mdl.step(16'h4101, RD, 8'h00, NC);
    mdl.step(16'h4102, OF, 8'h00, cf(odbt_pkg::CK_COND, 16'h7000, 16'h7100));
    mdl.step(16'h4103, RD, 8'h00, NC);
    mdl.step(16'h4000, OF, 8'h00, cf(odbt_pkg::CK_INDIR, 16'h4000, 16'h7777));
    mdl.rel();
    repeat (3) @(posedge clk_i);
    rc(odbt_pkg::ADR_DEBUG_STATUS_REG, 32'hf, 32'h2);
    rc(odbt_pkg::ADR_FIFOH, ALL, 32'h70);
    rc(odbt_pkg::ADR_FIFOL, ALL, 32'h00);
    rc(odbt_pkg::ADR_FIFOH, ALL, 32'h77);
    rc(odbt_pkg::ADR_FIFOL, ALL, 32'h77);
    $display("test change of flow done");
  endtask : t_cof

  task automatic t_prof;
    logic [31:0] q;
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h1);
    wr(odbt_pkg::ADR_DEBUG_CONTROL_REG, 32'h0);
    mdl.step(16'h8000, OF, 8'h00, NC);
    mdl.step(16'h8001, RD, 8'h00, NC);
    mdl.rel();
    // The first eight values only prime the queue and are thrown away
    repeat (8) wb(odbt_pkg::ADR_FIFOL, 1'b0, 32'h0, q);
    rc(odbt_pkg::ADR_FIFOH, ALL, 32'h80);
    rc(odbt_pkg::ADR_FIFOL, ALL, 32'h00);
    $display("test profiling done");
  endtask : t_prof

  // ********************************
  // Run control
  // ********************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_bg();
    t_cmp();
    t_evt();
    t_cof();
    t_prof();
    wrap_up();
  end
endmodule : odbt_top_tb
`default_nettype wire
